// ===== tdpc_pkg.sv
// Purpose: Shared constants and types for the dual-port RAM with collision marking
// Assumes: Both ports are sampled on mclk, each qualified by its own port enable
// Notes:   The poison bit rides above the data word inside the array
package tdpc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int DEPTH  = 256;
  localparam int NPORT  = 2;

  // Cross-port setup window and clock period, in ns
  localparam int WIN_NS = 20;
  localparam int CLK_NS = 10;
  // Least time: round up, never below one cycle
  localparam int WIN_CYC_RAW = (WIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN_CYC     = (WIN_CYC_RAW < 1) ? 1 : WIN_CYC_RAW;

  localparam int AGE_W = 3;
  // Age held while no recent write is pending
  localparam logic [AGE_W-1:0] AGE_IDLE  = AGE_W'(WIN_CYC);
  // Ages below this still fall inside the window
  localparam logic [AGE_W-1:0] AGE_NEAR  = AGE_W'(WIN_CYC - 1);
  localparam logic [AGE_W-1:0] AGE_RESET = AGE_W'(WIN_CYC);
  localparam logic [AGE_W-1:0] AGE_ONE   = 3'h1;

  typedef struct packed {
    logic              en;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
  } tdpc_req_t;

  typedef struct packed {
    logic              bad;
    logic [DATA_W-1:0] dout;
  } tdpc_rsp_t;

endpackage

// ===== tdpc_mem.sv
// Purpose: Two-port storage array with registered read words
// Assumes: Caller resolves collisions and supplies poison and bad marks
// Notes:   Array itself has no reset; only the read registers clear
`timescale 1ns/10ps
module tdpc_mem
  import tdpc_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        ce,
  input  wire tdpc_pkg::tdpc_req_t [1:0]  req,
  input  wire logic [1:0]                  rd_bad,
  input  wire logic [1:0]                  wr_poison,
  output tdpc_pkg::tdpc_rsp_t [1:0]        rsp_r
);

  logic [DATA_W:0] store [DEPTH];

  // Second port lands last on a same-cycle clash; both are poisoned then
  always_ff @(posedge mclk)
  begin
    if (ce)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        if (req[p].en && req[p].we)
          store[req[p].addr] <= {wr_poison[p], req[p].din};
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      rsp_r <= '0;
    else if (ce)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        // (RQ3) writer sees own word
        if (req[p].en && req[p].we)
          rsp_r[p] <= '{bad: 1'b0, dout: req[p].din};
        // (RQ8) (RQ9) read stored word; no access holds (RQ1) (RQ7)
        else if (req[p].en)
          rsp_r[p] <= '{bad: rd_bad[p] | store[req[p].addr][DATA_W],
                        dout: store[req[p].addr][DATA_W-1:0]};
      end
    end
  end

endmodule // tdpc_mem

// ===== tdpc_top.sv
// Purpose: True dual-port RAM that marks cross-port setup collisions
// Assumes: Port clocks are modelled as per-port enables on mclk
// Notes:   Collided data is reported with an invalid flag; words never written since power-up still read as X
//
// Summary of operation
// (RQ1) A disabled port holds its last read output unchanged.
// (RQ2) Each port samples its own operation independently on its own edge; here both ports sample on the shared mclk edge, each gated by its enable.
// (RQ3) A write stores data and mirrors it on the writer's own output.
// (RQ4) Collisions only count for same address with at least one write.
// (RQ5) Write-write collision in window leaves the location marked undefined.
// (RQ6) Write-read collision keeps memory written but flags reader output invalid.
// (RQ7) A write on one port never changes the other port's output.
// (RQ8) A later read by the other port returns the newly written value.
// (RQ9) A read after the window elapses shows the new data cleanly.
// (RQ10) Each port otherwise behaves like a single-port memory.
// (RQ11) User logic avoids collisions or discards the data they spoil.
`timescale 1ns/10ps
module tdpc_top
  import tdpc_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic                  ce,
  input  wire tdpc_pkg::tdpc_req_t  first_port_req,
  input  wire tdpc_pkg::tdpc_req_t  second_port_req,
  output logic [tdpc_pkg::DATA_W-1:0] first_port_read_output,
  output logic                       first_port_read_invalid,
  output logic [tdpc_pkg::DATA_W-1:0] second_port_read_output,
  output logic                       second_port_read_invalid
);

  tdpc_req_t [1:0]         req;
  tdpc_rsp_t [1:0]         rsp;
  logic [1:0]              col;
  logic [1:0]              rd_bad;
  logic [1:0]              wr_poison;
  logic [AGE_W-1:0]        age_r   [NPORT];
  logic [ADDR_W-1:0]       waddr_r [NPORT];

  // (RQ10) both ports index one shared array
  assign req = {second_port_req, first_port_req};

  // Window counted in whole cycles, so a sub-cycle gap still reads as a clash
  // (RQ4) same address and a write on the other side
  function automatic logic clash(input tdpc_req_t acc, input tdpc_req_t oth,
                                 input logic [ADDR_W-1:0] waddr,
                                 input logic [AGE_W-1:0] age);
    logic now_hit;
    logic near_hit;
    now_hit  = oth.en && oth.we && (oth.addr == acc.addr);
    near_hit = (age < AGE_NEAR) && (waddr == acc.addr);
    return acc.en && (now_hit || near_hit);
  endfunction

  genvar g;
  generate
    for (g = 0; g < NPORT; g++)
    begin : g_port
      // (RQ2) each port tracks its own last write age
      always_ff @(posedge mclk)
      begin
        if (srst)
          age_r[g] <= AGE_RESET;
        else if (ce)
        begin
          if (req[g].en && req[g].we)
            age_r[g] <= '0;
          else if (age_r[g] < AGE_IDLE)
            age_r[g] <= age_r[g] + AGE_ONE;
        end
      end

      always_ff @(posedge mclk)
      begin
        if (srst)
          waddr_r[g] <= '0;
        else if (ce && req[g].en && req[g].we)
          waddr_r[g] <= req[g].addr;
      end

      assign col[g] = clash(req[g], req[1-g], waddr_r[1-g], age_r[1-g]);
      // (RQ6) reader flagged, stored word untouched
      assign rd_bad[g]    = col[g] && !req[g].we;
      // (RQ5) write over a recent write poisons the location
      assign wr_poison[g] = col[g] && req[g].we;
    end
  endgenerate

  // (RQ1) hold and (RQ3) write-through live in the registered read stage
  // (RQ7) (RQ8) only a port's own access moves its output
  tdpc_mem tdpc_mem_i (
    .mclk      (mclk),
    .srst      (srst),
    .ce        (ce),
    .req       (req),
    .rd_bad    (rd_bad),
    .wr_poison (wr_poison),
    .rsp_r     (rsp)
  );

  assign first_port_read_output   = rsp[0].dout;
  assign first_port_read_invalid  = rsp[0].bad;
  assign second_port_read_output  = rsp[1].dout;
  assign second_port_read_invalid = rsp[1].bad;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_a_write;
    ce && first_port_req.en && first_port_req.we && !second_port_req.en;
  endsequence

  sequence s_both_idle;
    ce && !first_port_req.en && !second_port_req.en;
  endsequence

  sequence s_ww_same;
    ce && first_port_req.en && first_port_req.we && second_port_req.en
      && second_port_req.we && first_port_req.addr == second_port_req.addr;
  endsequence

  sequence s_b_write;
    ce && second_port_req.en && second_port_req.we && !first_port_req.en;
  endsequence

  sequence s_a_read;
    ce && first_port_req.en && !first_port_req.we && !second_port_req.en;
  endsequence

  sequence s_b_read;
    ce && second_port_req.en && !second_port_req.we && !first_port_req.en;
  endsequence

  sequence s_rw_same;
    ce && first_port_req.en && !first_port_req.we && second_port_req.en
      && second_port_req.we && first_port_req.addr == second_port_req.addr;
  endsequence

  chk_hold_disabled: assert property ( // RQ1
    ce && !first_port_req.en |=> $stable(first_port_read_output)
      && $stable(first_port_read_invalid))
    else $error("First port output moved while disabled");

  chk_ce_freeze: assert property ( // RQ2
    !ce |=> $stable(first_port_read_output) && $stable(second_port_read_output)
      && $stable(first_port_read_invalid) && $stable(second_port_read_invalid))
    else $error("Output moved with clock enable low");

  chk_a_write_thru: assert property ( // RQ3
    ce && first_port_req.en && first_port_req.we
      |=> first_port_read_output == $past(first_port_req.din)
        && !first_port_read_invalid)
    else $error("First port write not mirrored");

  chk_b_read_free: assert property ( // RQ4
    s_both_idle ##1 s_both_idle ##1 s_b_read |-> !rd_bad[1])
    else $error("Read flagged with no write nearby");

  chk_ww_poison: assert property ( // RQ5
    s_ww_same ##1 s_both_idle ##1 s_a_read
      ##0 (first_port_req.addr == $past(first_port_req.addr, 2))
      |=> first_port_read_invalid)
    else $error("Write-write clash not marked undefined");

  chk_wr_invalid: assert property ( // RQ6
    ce && first_port_req.en && first_port_req.we && second_port_req.en
      && !second_port_req.we && first_port_req.addr == second_port_req.addr
      |=> second_port_read_invalid && first_port_read_output == $past(first_port_req.din))
    else $error("Write-read clash reader not flagged");

  chk_other_keeps: assert property ( // RQ7
    s_a_write |=> $stable(second_port_read_output) && $stable(second_port_read_invalid))
    else $error("Write on first port disturbed second output");

  chk_late_read: assert property ( // RQ8
    s_a_write ##1 s_both_idle [*2] ##1 (ce && second_port_req.en && !second_port_req.we
      && !first_port_req.en && second_port_req.addr == $past(first_port_req.addr, 3))
      |=> second_port_read_output == $past(first_port_req.din, 4))
    else $error("Later read missed new data");

  chk_after_window: assert property ( // RQ9
    s_a_write ##1 s_both_idle [*2] ##1 (ce && second_port_req.en && !second_port_req.we
      && !first_port_req.en && second_port_req.addr == $past(first_port_req.addr, 3))
      |=> !second_port_read_invalid)
    else $error("Read after window still flagged");

  chk_b_write_thru: assert property ( // RQ10
    ce && second_port_req.en && second_port_req.we
      |=> second_port_read_output == $past(second_port_req.din)
        && !second_port_read_invalid)
    else $error("Second port write not mirrored");

  chk_hold_b: assert property ( // RQ1
    ce && !second_port_req.en |=> $stable(second_port_read_output)
      && $stable(second_port_read_invalid))
    else $error("Second port output moved while disabled");

  chk_b_keeps_a: assert property ( // RQ7
    s_b_write |=> $stable(first_port_read_output) && $stable(first_port_read_invalid))
    else $error("Write on second port disturbed first output");

  chk_rw_invalid: assert property ( // RQ6
    s_rw_same |=> first_port_read_invalid
      && second_port_read_output == $past(second_port_req.din))
    else $error("Read-write clash reader not flagged");

  chk_a_read_free: assert property ( // RQ4
    s_both_idle ##1 s_both_idle ##1 s_a_read |-> !rd_bad[0])
    else $error("First port read flagged with no write nearby");

  chk_b_late_read: assert property ( // RQ9
    s_b_write ##1 s_both_idle [*2] ##1 s_a_read
      ##0 (first_port_req.addr == $past(second_port_req.addr, 3))
      |=> first_port_read_output == $past(second_port_req.din, 4)
        && !first_port_read_invalid)
    else $error("First port late read missed new data");

  // Reset acts even with the enable low, so this one is never disabled
  chk_reset_clear: assert property ( // RQ10
    disable iff (1'b0) srst |=> first_port_read_output == '0 && !first_port_read_invalid
      && second_port_read_output == '0 && !second_port_read_invalid)
    else $error("Outputs not cleared by reset");

endmodule // tdpc_top

// ===== tdpc_user.sv
// Purpose: User logic model driving both RAM port requests
// Assumes: put is called just after a rising edge
// Notes:   Idle ports scramble address and data, never hold them
`timescale 1ns/10ps
module tdpc_user
(
  output tdpc_pkg::tdpc_req_t req_a,
  output tdpc_pkg::tdpc_req_t req_b
);
  import tdpc_pkg::*;

  initial req_a = '0;
  initial req_b = '0;

  task automatic put(input tdpc_req_t a, input tdpc_req_t b);
    req_a <= a.en ? a : {2'b00, ~req_a.addr, ~req_a.din};
    req_b <= b.en ? b : {2'b00, ~req_b.addr, ~req_b.din};
  endtask
endmodule // tdpc_user

// ===== tb_tdpc_top.sv
// Purpose: Self-checking bench for the collision-marking dual-port RAM
// Assumes: Requests reach the ports through tdpc_user
// Notes:   Collided words are judged by their invalid flag only
`timescale 1ns/10ps
module tb_tdpc_top;
  import tdpc_pkg::*;
  localparam tdpc_req_t I = '0;
  logic              mclk;
  logic              srst;
  logic              ce;
  tdpc_req_t         req_a;
  tdpc_req_t         req_b;
  logic [DATA_W-1:0] da;
  logic [DATA_W-1:0] db;
  logic              ia;
  logic              ib;
  int                fails;
  int                n_compared;

  tdpc_top tdpc_top_i (.mclk(mclk), .srst(srst), .ce(ce),
    .first_port_req(req_a), .second_port_req(req_b),
    .first_port_read_output(da), .first_port_read_invalid(ia),
    .second_port_read_output(db), .second_port_read_invalid(ib));
  tdpc_user tdpc_user_i (.req_a(req_a), .req_b(req_b));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic tdpc_req_t wr(input logic [7:0] a, input logic [15:0] d);
    return {2'b11, a, d};
  endfunction
  function automatic tdpc_req_t rd(input logic [7:0] a);
    return {2'b10, a, 16'h0000};
  endfunction

  task automatic cyc(input tdpc_req_t a, input tdpc_req_t b);
    @(posedge mclk);
    tdpc_user_i.put(a, b);
  endtask
  // One idle edge lets the last request land
  task automatic settle();
    cyc(I, I);
    #1;
  endtask
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic t_mirror();
    cyc(wr(8'h00, 16'h1111), I);
    cyc(I, I);
    cyc(I, rd(8'h00));
    cyc(wr(8'h00, 16'haaaa), I);
    settle();
    chk({ia, da}, {1'b0, 16'haaaa});
    chk({ib, db}, {1'b0, 16'h1111});
    cyc(I, rd(8'h00));
    settle();
    chk({ib, db}, {1'b0, 16'haaaa});
    $display("mirror done");
  endtask

  task automatic t_window();
    for (int d = 0; d < 4; d++)
    begin
      logic [16:0] e;
      e = {1'b0, 16'h9990} + 17'(d);
      cyc(wr(8'h7e, e[15:0]), d == 0 ? rd(8'h7e) : I);
      for (int k = 1; k < d; k++)
        cyc(I, I);
      if (d > 0)
        cyc(I, rd(8'h7e));
      settle();
      chk({ia, da}, e);
      if (d < WIN_CYC)
        chk({ib, 16'h0000}, {1'b1, 16'h0000});
      else
        chk({ib, db}, e);
      cyc(I, rd(8'h7e));
      settle();
      chk({ib, db}, e);
    end
    $display("window done");
  endtask

  task automatic t_ww();
    cyc(wr(8'h40, 16'h1234), wr(8'h40, 16'h5678));
    cyc(I, I);
    cyc(rd(8'h40), I);
    settle();
    chk({ia, 16'h0000}, {1'b1, 16'h0000});
    cyc(wr(8'h40, 16'h0f0f), wr(8'h41, 16'hf0f0));
    cyc(I, I);
    cyc(rd(8'h41), rd(8'h40));
    settle();
    chk({ia, da}, {1'b0, 16'hf0f0});
    chk({ib, db}, {1'b0, 16'h0f0f});
    $display("ww done");
  endtask

  task automatic t_hold();
    @(posedge mclk);
    ce <= 1'b0;
    tdpc_user_i.put(wr(8'h41, 16'hdead), rd(8'h00));
    @(posedge mclk);
    ce <= 1'b1;
    tdpc_user_i.put(I, I);
    settle();
    chk({ia, da}, {1'b0, 16'hf0f0});
    chk({ib, db}, {1'b0, 16'h0f0f});
    cyc(I, rd(8'h41));
    settle();
    chk({ib, db}, {1'b0, 16'hf0f0});
    $display("hold done");
  endtask

  task automatic t_rev();
    cyc(I, wr(8'h42, 16'h5a5a));
    cyc(rd(8'h42), wr(8'h42, 16'ha5a5));
    settle();
    chk({ia, 16'h0000}, {1'b1, 16'h0000});
    chk({ib, db}, {1'b0, 16'ha5a5});
    cyc(rd(8'h42), I);
    settle();
    chk({ia, da}, {1'b0, 16'ha5a5});
    cyc(I, wr(8'h43, 16'hc3c3));
    cyc(I, I);
    cyc(I, I);
    cyc(rd(8'h43), I);
    settle();
    chk({ia, da}, {1'b0, 16'hc3c3});
    chk({ib, db}, {1'b0, 16'hc3c3});
    $display("rev done");
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #20000;
    fails++;
    complete_run();
  end

  initial
  begin
    fails = 0;
    n_compared = 0;
    srst = 1'b1;
    ce = 1'b1;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    #1;
    chk({ia, da}, 17'h00000);
    chk({ib, db}, 17'h00000);
    t_mirror();
    t_window();
    t_ww();
    t_hold();
    t_rev();
    complete_run();
  end
endmodule // tb_tdpc_top
